// file: common/sbis_cfg.svh
// register offsets, field positions, reset values and timing counts of the brake sequencer
`ifndef SBIS_CFG_SVH
`define SBIS_CFG_SVH

`define SBIS_OFF_FUNC       8'h00
`define SBIS_OFF_DELAY      8'h04
`define SBIS_OFF_STATUS     8'h08
`define SBIS_OFF_INT_STATUS 8'h0c
`define SBIS_OFF_INT_CLEAR  8'h10
`define SBIS_OFF_INT_ENABLE 8'h14

`define SBIS_RST_FUNC       16'h0000
`define SBIS_RST_DELAY      16'h0064
`define SBIS_BRAKE_CODE     16'hddd1

`define SBIS_INT_RUN        0
`define SBIS_INT_STOP       1
`define SBIS_INT_TRIP       2
`define SBIS_INT_FAULT      3
`define SBIS_INT_W          4

`define SBIS_CLK_HZ         10000000
`define SBIS_TICK_MS        1
`define SBIS_CYC_PER_MS     ((`SBIS_CLK_HZ / 1000) * `SBIS_TICK_MS)

`endif

// file: common/sbis_pkg.sv
// types of the brake interlock sequencer
`include "sbis_cfg.svh"
package sbis_pkg;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_RUN  = 3'b001,
		S_STOP = 3'b010,
		S_TRIP = 3'b011
	} sbis_state_t;

	typedef struct packed {
		sbis_state_t               state;
		logic                      en_s1;
		logic                      en_s2;
		logic                      clr_s1;
		logic                      clr_s2;
		logic                      halt_s1;
		logic                      halt_s2;
		logic                      alm_s1;
		logic                      alm_s2;
		logic                      clr_prev;
		logic                      fault;
		logic [15:0]               func_sel;
		logic [15:0]               brake_delay;
		logic [`SBIS_INT_W-1:0]    int_status;
		logic [`SBIS_INT_W-1:0]    int_enable;
		logic                      pready;
		logic                      pslverr;
		logic [31:0]               prdata;
		logic                      irq;
		logic                      brake;
		logic                      power;
		logic                      tmr_start;
	} sbis_top_st_t;

	typedef struct packed {
		logic        busy;
		logic        done;
		logic [15:0] ms_left;
		logic [15:0] pre;
	} sbis_tmr_st_t;
endpackage : sbis_pkg

// file: common/sbis_tmr_if.sv
// link between the sequencer and its millisecond delay timer
`timescale 1ns/1ns
`default_nettype none
interface sbis_tmr_if;
	logic        start;
	logic        cancel;
	logic [15:0] load_ms;
	logic        done;
	logic        busy;
	modport ctl (output start, output cancel, output load_ms, input done, input busy);
	modport tmr (input start, input cancel, input load_ms, output done, output busy);
endinterface : sbis_tmr_if
`default_nettype wire

// file: src/sbis_timer.sv
// millisecond delay timer used between brake engagement and power-stage shut-off
`timescale 1ns/1ns
`default_nettype none
`include "sbis_cfg.svh"
module sbis_timer
	import sbis_pkg::*;
#(
	parameter int CYC_PER_MS = `SBIS_CYC_PER_MS
)(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	sbis_tmr_if.tmr   tmr
);
	localparam logic [15:0] PRE_LAST = 16'(CYC_PER_MS - 1);

	sbis_tmr_st_t st;
	sbis_tmr_st_t next_st;

	assign tmr.done = st.done;
	assign tmr.busy = st.busy;

	always_comb
	begin
		next_st = st;
		next_st.done = 1'b0;
		if (tmr.start)
		begin
			next_st.busy = 1'b1;
			next_st.ms_left = tmr.load_ms;
			next_st.pre = 16'h0000;
		end
		else if (tmr.cancel)
		begin
			// an abandoned stop must not leave a late done behind
			next_st.busy = 1'b0;
		end
		else if (st.busy)
		begin
			if (st.ms_left == 16'h0000)
			begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end
			else if (st.pre == PRE_LAST)
			begin
				next_st.pre = 16'h0000;
				next_st.ms_left = st.ms_left - 16'h0001;
			end
			else
			begin
				next_st.pre = st.pre + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			st <= '0;
		else
			st <= next_st;
	end
endmodule : sbis_timer
`default_nettype wire

// file: src/sbis_top.sv
// brake interlock sequencer: pin sync, state machine, apb registers, interrupt
`timescale 1ns/1ns
`default_nettype none
`include "sbis_cfg.svh"
module sbis_top
	import sbis_pkg::*;
#(
	parameter int CYC_PER_MS = `SBIS_CYC_PER_MS
)(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        drive_enable_in,
	input  wire logic        fault_clear_in,
	input  wire logic        halt_in,
	input  wire logic        alarm_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic             pready_out,
	output logic             pslverr_out,
	output logic [31:0]      prdata_out,
	output logic             brake_hold_out,
	output logic             power_stage_on_out,
	output logic             fault_out,
	output logic             irq_out
);
	sbis_top_st_t st;
	sbis_top_st_t next_st;
	sbis_tmr_if   tmr ();

	function automatic logic sbis_reg_hit(input logic [7:0] addr);
		case (addr)
			`SBIS_OFF_FUNC,
			`SBIS_OFF_DELAY,
			`SBIS_OFF_STATUS,
			`SBIS_OFF_INT_STATUS,
			`SBIS_OFF_INT_CLEAR,
			`SBIS_OFF_INT_ENABLE: sbis_reg_hit = 1'b1;
			default:              sbis_reg_hit = 1'b0;
		endcase
	endfunction : sbis_reg_hit

	function automatic logic sbis_brake_valid(input logic [15:0] func);
		sbis_brake_valid = (func == `SBIS_BRAKE_CODE);
	endfunction : sbis_brake_valid

	sbis_timer #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_timer (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.tmr      (tmr)
	);

	assign tmr.start   = st.tmr_start;
	assign tmr.load_ms = st.brake_delay;
	assign tmr.cancel  = (st.state != S_STOP);

	assign pready_out         = st.pready;
	assign pslverr_out        = st.pslverr;
	assign prdata_out         = st.prdata;
	assign brake_hold_out     = st.brake;
	assign power_stage_on_out = st.power;
	assign fault_out          = st.fault;
	assign irq_out            = st.irq;

	logic                   trip_cond;
	logic                   clr_rise;
	logic                   setup_ph;
	logic                   wr_acc;
	logic [`SBIS_INT_W-1:0] events;

	always_comb
	begin
		next_st = st;
		events = '0;

		next_st.en_s1   = drive_enable_in;
		next_st.en_s2   = st.en_s1;
		next_st.clr_s1  = fault_clear_in;
		next_st.clr_s2  = st.clr_s1;
		next_st.halt_s1 = halt_in;
		next_st.halt_s2 = st.halt_s1;
		next_st.alm_s1  = alarm_in;
		next_st.alm_s2  = st.alm_s1;
		next_st.clr_prev = st.clr_s2;

		// the fault stays latched until a clear edge arrives with the alarm gone
		clr_rise = st.clr_s2 & ~st.clr_prev;
		if (st.alm_s2)
			next_st.fault = 1'b1;
		else if (clr_rise)
			next_st.fault = 1'b0;

		// a held clear also forces the power stage off, like a halt
		trip_cond = st.halt_s2 | st.alm_s2 | st.fault | st.clr_s2;

		case (st.state)
			S_IDLE:
			begin
				if (trip_cond)
					next_st.state = S_TRIP;
				else if (st.en_s2)
					next_st.state = S_RUN;
			end
			S_RUN:
			begin
				if (trip_cond)
					next_st.state = S_TRIP;
				else if (!st.en_s2)
					next_st.state = S_STOP;
			end
			S_STOP:
			begin
				if (trip_cond)
					next_st.state = S_TRIP;
				else if (tmr.done)
					next_st.state = S_IDLE;
			end
			S_TRIP:
			begin
				if (!trip_cond)
					next_st.state = S_IDLE;
			end
			default:
			begin
				next_st.state = S_IDLE;
			end
		endcase

		next_st.tmr_start = (next_st.state == S_STOP) && (st.state != S_STOP);
		// power is held through the stop delay so the load stays locked while the brake bites
		next_st.power = (next_st.state == S_RUN) || (next_st.state == S_STOP);
		// high releases the brake, so any unplanned loss of drive engages it
		next_st.brake = (next_st.state == S_RUN) && sbis_brake_valid(st.func_sel);

		events[`SBIS_INT_RUN]   = (next_st.state == S_RUN) && (st.state != S_RUN);
		events[`SBIS_INT_STOP]  = (st.state == S_STOP) && (next_st.state == S_IDLE);
		events[`SBIS_INT_TRIP]  = (next_st.state == S_TRIP) && (st.state != S_TRIP);
		events[`SBIS_INT_FAULT] = st.alm_s2 & ~st.fault;

		setup_ph = psel_in & ~penable_in;
		wr_acc = psel_in & penable_in & st.pready & pwrite_in;
		next_st.pready = setup_ph;

		if (setup_ph)
		begin
			next_st.pslverr = ~sbis_reg_hit(paddr_in);
			next_st.prdata = 32'h00000000;
			if (!pwrite_in)
			begin
				case (paddr_in)
					`SBIS_OFF_FUNC:       next_st.prdata = {16'h0000, st.func_sel};
					`SBIS_OFF_DELAY:      next_st.prdata = {16'h0000, st.brake_delay};
					`SBIS_OFF_STATUS:     next_st.prdata = {23'h0, st.en_s2, st.fault,
					                                        st.power, st.brake, st.halt_s2,
					                                        st.clr_s2, st.state};
					`SBIS_OFF_INT_STATUS: next_st.prdata = {28'h0000000, st.int_status};
					`SBIS_OFF_INT_ENABLE: next_st.prdata = {28'h0000000, st.int_enable};
					default:              next_st.prdata = 32'h00000000;
				endcase
			end
		end

		next_st.int_status = st.int_status;
		if (wr_acc)
		begin
			case (paddr_in)
				`SBIS_OFF_FUNC:       next_st.func_sel = pwdata_in[15:0];
				`SBIS_OFF_DELAY:      next_st.brake_delay = pwdata_in[15:0];
				`SBIS_OFF_INT_CLEAR:  next_st.int_status = st.int_status & ~pwdata_in[3:0];
				`SBIS_OFF_INT_ENABLE: next_st.int_enable = pwdata_in[3:0];
				default:              next_st.int_enable = st.int_enable;
			endcase
		end
		// a new event beats a clear written in the same cycle
		next_st.int_status = next_st.int_status | events;
		next_st.irq = |(next_st.int_status & next_st.int_enable);
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			st <= '0;
			st.state <= S_IDLE;
			st.func_sel <= `SBIS_RST_FUNC;
			st.brake_delay <= `SBIS_RST_DELAY;
		end
		else
		begin
			st <= next_st;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_servo_off;
		(st.state == S_RUN) && !st.en_s2 && !trip_cond;
	endsequence

	sequence s_brake_wait;
		!brake_hold_out && power_stage_on_out && tmr.start;
	endsequence

	sequence s_delay_end;
		(st.state == S_STOP) && tmr.done && !trip_cond;
	endsequence

	property p_brake_code;
		brake_hold_out |-> $past(sbis_brake_valid(st.func_sel));
	endproperty
	a_brake_code: assert property (p_brake_code)
		else $error("brake hold driven without the brake function code");

	property p_brake_pol;
		brake_hold_out |-> power_stage_on_out && (st.state == S_RUN);
	endproperty
	a_brake_pol: assert property (p_brake_pol)
		else $error("brake released while the drive is not running");

	property p_clear_off;
		st.clr_s2 |=> !power_stage_on_out && !brake_hold_out;
	endproperty
	a_clear_off: assert property (p_clear_off)
		else $error("power stage on while fault clear held");

	property p_stop_seq;
		s_servo_off |=> s_brake_wait;
	endproperty
	a_stop_seq: assert property (p_stop_seq)
		else $error("servo-off did not engage brake and start the delay");

	property p_delay_load;
		tmr.start |=> tmr.busy && (u_timer.st.ms_left == $past(st.brake_delay));
	endproperty
	a_delay_load: assert property (p_delay_load)
		else $error("delay timer not loaded with the brake delay");

	property p_delay_end;
		s_delay_end |=> !power_stage_on_out && (st.state == S_IDLE);
	endproperty
	a_delay_end: assert property (p_delay_end)
		else $error("power stage not shut off when the delay ended");

	property p_hold_in_stop;
		(st.state == S_STOP) && !tmr.done && !trip_cond |=> power_stage_on_out;
	endproperty
	a_hold_in_stop: assert property (p_hold_in_stop)
		else $error("power dropped before the brake delay elapsed");

	property p_halt_trip;
		st.halt_s2 |=> !brake_hold_out && !power_stage_on_out;
	endproperty
	a_halt_trip: assert property (p_halt_trip)
		else $error("halt did not engage brake and cut power");

	property p_alarm_trip;
		st.alm_s2 |=> fault_out && !power_stage_on_out ##1 !brake_hold_out;
	endproperty
	a_alarm_trip: assert property (p_alarm_trip)
		else $error("alarm did not latch fault and cut power");

	property p_irq_level;
		irq_out == |(st.int_status & st.int_enable);
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt output does not follow enabled status");
endmodule : sbis_top
`default_nettype wire

// file: dv/sbis_host_model.sv
// host controller and external brake relay seen from the sequencer's pins
`timescale 1ns/1ns
`default_nettype none
module sbis_host_model #(
	parameter int REL_CYC = 2
)(
	input  wire logic clk_in,
	input  wire logic servo_req_in,
	input  wire logic standstill_in,
	input  wire logic estop_in,
	input  wire logic brake_hold_in,
	input  wire logic fault_in,
	output var logic  drive_enable_out = 1'b0,
	output logic      brake_supply_out,
	output logic      pos_cmd_ok_out
);
	int rel_cnt = 0;

	// servo-off is held back until the axis reports standstill
	always @(posedge clk_in)
	begin
		if (servo_req_in)
			drive_enable_out <= 1'b1;
		else if (standstill_in)
			drive_enable_out <= 1'b0;
	end

	// release time of brake plus relay, counted while the coil is fed
	always @(posedge clk_in)
	begin
		if (!brake_supply_out)
			rel_cnt <= 0;
		else if (rel_cnt < REL_CYC)
			rel_cnt <= rel_cnt + 1;
	end

	assign pos_cmd_ok_out = brake_supply_out && (rel_cnt == REL_CYC);

	// relay contacts are in series, so any one of them opens the coil supply
	assign brake_supply_out = drive_enable_out & ~fault_in & brake_hold_in & ~estop_in;
endmodule : sbis_host_model
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the brake interlock sequencer
`timescale 1ns/1ns
`default_nettype none
`include "sbis_cfg.svh"
module tb_top;
	localparam int CPM = 4;
	localparam int DLY = 3;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        servo_req = 1'b0;
	logic        standstill = 1'b0;
	logic        clr = 1'b0;
	logic        hlt = 1'b0;
	logic        fault_output = 1'b0;
	logic        estop = 1'b0;
	wire         brake_supply;
	wire         pos_ok;
	logic        psel_in = 1'b0;
	logic        penable_in = 1'b0;
	logic        pwrite_in = 1'b0;
	logic [7:0]  paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0;
	wire         drive_en;
	wire         pready_out;
	wire         pslverr_out;
	wire  [31:0] prdata_out;
	wire         brake_hold_out;
	wire         power_stage_on_out;
	wire         fault_out;
	wire         irq_out;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          n;

	always #50 clk_in = ~clk_in;

	sbis_top #(.CYC_PER_MS(CPM)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.drive_enable_in(drive_en), .fault_clear_in(clr), .halt_in(hlt), .alarm_in(fault_output),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .prdata_out(prdata_out), .brake_hold_out(brake_hold_out),
		.power_stage_on_out(power_stage_on_out), .fault_out(fault_out), .irq_out(irq_out));

	sbis_host_model #(.REL_CYC(2)) host (.clk_in(clk_in), .servo_req_in(servo_req),
		.standstill_in(standstill), .estop_in(estop), .brake_hold_in(brake_hold_out),
		.fault_in(fault_out), .drive_enable_out(drive_en), .brake_supply_out(brake_supply),
		.pos_cmd_ok_out(pos_ok));

	task finish_test;
		if (error_cnt == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one apb transfer; an idle cycle follows so strobes never toggle twice in a step
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [32:0] q);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		q = {pslverr_out, prdata_out};
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge clk_in);
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [32:0] q;
		apb(1'b1, a, d, q);
	endtask : wr

	task rd(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic err);
		logic [32:0] q;
		apb(1'b0, a, 32'h0, q);
		chk(nm, q[31:0], exp);
		chk("pslverr", {31'h0, q[32]}, {31'h0, err});
	endtask : rd

	// pins need two sync edges and one output edge; a few extra cover trip exit
	task pins(input logic on, input logic c, input logic h, input logic a);
		servo_req <= on;
		standstill <= ~on;
		clr <= c;
		hlt <= h;
		fault_output <= a;
		repeat (8) @(posedge clk_in);
	endtask : pins

	task outs(input logic b, input logic p, input logic f);
		chk("brake_hold", {31'h0, brake_hold_out}, {31'h0, b});
		chk("power_stage", {31'h0, power_stage_on_out}, {31'h0, p});
		chk("fault", {31'h0, fault_out}, {31'h0, f});
		chk("brake_supply", {31'h0, brake_supply}, {31'h0, b});
		chk("pos_cmd_ok", {31'h0, pos_ok}, {31'h0, b});
	endtask : outs

	initial
	begin
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		outs(1'b0, 1'b0, 1'b0);
		rd("func_rst", `SBIS_OFF_FUNC, 32'h0, 1'b0);
		rd("delay_rst", `SBIS_OFF_DELAY, 32'h64, 1'b0);
		rd("unmapped", 8'h20, 32'h0, 1'b1);
		wr(`SBIS_OFF_INT_ENABLE, 32'h2);
		pins(1'b1, 1'b0, 1'b0, 1'b0);
		outs(1'b0, 1'b1, 1'b0);
		chk("irq_masked", {31'h0, irq_out}, 32'h0);
		wr(`SBIS_OFF_FUNC, 32'hddd1);
		wr(`SBIS_OFF_DELAY, DLY);
		rd("func", `SBIS_OFF_FUNC, 32'hddd1, 1'b0);
		repeat (2) @(posedge clk_in);
		outs(1'b1, 1'b1, 1'b0);
		rd("status_run", `SBIS_OFF_STATUS, 32'h161, 1'b0);
		servo_req <= 1'b0;
		standstill <= 1'b1;
		repeat (5) @(posedge clk_in);
		outs(1'b0, 1'b1, 1'b0);
		n = 5;
		while (power_stage_on_out !== 1'b0)
		begin
			@(posedge clk_in);
			n++;
		end
		chk("delay_min", {31'h0, n >= DLY * CPM}, 32'h1);
		chk("delay_max", {31'h0, n <= DLY * CPM + 10}, 32'h1);
		outs(1'b0, 1'b0, 1'b0);
		chk("irq_set", {31'h0, irq_out}, 32'h1);
		rd("int_status", `SBIS_OFF_INT_STATUS, 32'h3, 1'b0);
		wr(`SBIS_OFF_INT_CLEAR, 32'hf);
		chk("irq_clr", {31'h0, irq_out}, 32'h0);
		rd("int_cleared", `SBIS_OFF_INT_STATUS, 32'h0, 1'b0);
		pins(1'b1, 1'b0, 1'b0, 1'b0);
		pins(1'b1, 1'b0, 1'b1, 1'b0);
		outs(1'b0, 1'b0, 1'b0);
		pins(1'b1, 1'b0, 1'b0, 1'b0);
		outs(1'b1, 1'b1, 1'b0);
		pins(1'b1, 1'b0, 1'b0, 1'b1);
		outs(1'b0, 1'b0, 1'b1);
		pins(1'b1, 1'b0, 1'b0, 1'b0);
		outs(1'b0, 1'b0, 1'b1);
		pins(1'b1, 1'b1, 1'b0, 1'b0);
		outs(1'b0, 1'b0, 1'b0);
		pins(1'b1, 1'b0, 1'b0, 1'b0);
		outs(1'b1, 1'b1, 1'b0);
		estop <= 1'b1;
		@(posedge clk_in);
		chk("estop_supply", {31'h0, brake_supply}, 32'h0);
		chk("estop_brake_hold", {31'h0, brake_hold_out}, 32'h1);
		finish_test();
	end

	// the sequence needs well under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk_in);
		error_cnt++;
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
